// *** hdl/rcss_pkg.sv ***
// Constants and types for the relay channel switch sequencer
package rcss_pkg;
   localparam int NUM_SLOTS = 12;
   localparam int NUM_CHANS = 22;
   localparam int FOUR_WIRE_CHANS = 11;
   localparam int SENSE_OFFSET = 11;
   localparam int SLOT_FACTOR = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
   localparam int OPEN_SETTLE_MS = 5;
   localparam int CLOSE_SETTLE_MS = 5;
   localparam int SWITCH_TIME_MS = 11;
   localparam int GAP_MS = SWITCH_TIME_MS - OPEN_SETTLE_MS - CLOSE_SETTLE_MS;
   localparam int OPEN_SETTLE_CYC = OPEN_SETTLE_MS * CYC_PER_MS;
   localparam int CLOSE_SETTLE_CYC = CLOSE_SETTLE_MS * CYC_PER_MS;
   localparam int GAP_CYC = GAP_MS * CYC_PER_MS;
   localparam int DELAY_MAX_MS = 9999;
   localparam int DELAY_W = 14;
   localparam int WIDTH_W = 8;
   localparam int NUM_W = 16;
   localparam int SLOT_W = 4;
   localparam int CHAN_W = 5;
   localparam int TMR_W = 32;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 14'h0000;
   typedef enum logic [2:0] {
      RCSS_IDLE,
      RCSS_OPEN,
      RCSS_GAP,
      RCSS_CLOSE,
      RCSS_DELAY
   } rcss_state_t;
endpackage

// *** hdl/rcss_tmr_if.sv ***
// Start, abort and expiry signals between the sequencer and a timer
`timescale 1ns/10ps
interface rcss_tmr_if;
   import rcss_pkg::*;
   logic start;
   logic abort;
   logic [TMR_W-1:0] load;
   logic expired;
   logic busy;
   modport ctrl (output start, output abort, output load, input expired, input busy);
   modport tmr (input start, input abort, input load, output expired, output busy);
endinterface

// *** hdl/rcss_timer.sv ***
// Down counter that expires after a loaded number of cycles
`timescale 1ns/10ps
module rcss_timer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n_sync,
   input wire logic clk_en,
   // Control
   rcss_tmr_if.tmr t
);
   import rcss_pkg::*;
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic busy;
   } rcss_tmr_st_t;
   rcss_tmr_st_t st_q, st_d;

   assign t.expired = st_q.busy && (st_q.cnt <= TMR_W'(1));
   assign t.busy = st_q.busy;

   always_comb begin
      st_d = st_q;
      if (t.abort) begin
         st_d.busy = 1'b0;
      end else if (t.start) begin
         st_d.busy = 1'b1;
         st_d.cnt = t.load;
      end else if (t.expired) begin
         st_d.busy = 1'b0;
      end else if (st_q.busy) begin
         st_d.cnt = st_q.cnt - TMR_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end
endmodule

// *** hdl/rcss_sequencer.sv ***
// Channel switch sequencer: break-before-make relay control and completion pulse
`timescale 1ns/10ps
module rcss_sequencer #(
   parameter int OPEN_CYC = rcss_pkg::OPEN_SETTLE_CYC,
   parameter int GAP_SETTLE_CYC = rcss_pkg::GAP_CYC,
   parameter int CLOSE_CYC = rcss_pkg::CLOSE_SETTLE_CYC,
   parameter int MS_CYC = rcss_pkg::CYC_PER_MS
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Channel selection
   input wire logic sel_valid,
   input wire logic [rcss_pkg::NUM_W-1:0] sel_number,
   output logic sel_ready,
   output logic sel_error,
   input wire logic open_all,
   // Configuration
   input wire logic method_wr,
   input wire logic [rcss_pkg::SLOT_W-1:0] method_slot,
   input wire logic method_four_wire,
   input wire logic delay_wr,
   input wire logic [rcss_pkg::SLOT_W-1:0] delay_slot,
   input wire logic [rcss_pkg::DELAY_W-1:0] delay_ms,
   input wire logic [rcss_pkg::WIDTH_W-1:0] pulse_width_ms,
   // Status
   output logic switch_done,
   output logic switch_busy,
   // Relays and routing
   output logic [rcss_pkg::NUM_SLOTS-1:0] bus_relay,
   output logic [rcss_pkg::NUM_SLOTS*rcss_pkg::NUM_CHANS-1:0] chan_relay,
   output logic [rcss_pkg::NUM_SLOTS-1:0] term2_route,
   // External handshake port
   output logic close_pulse
);
   import rcss_pkg::*;

   typedef struct packed {
      rcss_state_t fsm;
      logic [SLOT_W-1:0] cur_slot;
      logic [CHAN_W-1:0] cur_ch;
      logic ch_closed;
      logic bus_closed;
      logic [SLOT_W-1:0] bus_slot;
      logic [SLOT_W-1:0] new_slot;
      logic [CHAN_W-1:0] new_ch;
      logic pend_v;
      logic [SLOT_W-1:0] pend_slot;
      logic [CHAN_W-1:0] pend_ch;
      logic done;
      logic pulse;
      logic err;
      logic [NUM_SLOTS-1:0] four_wire;
      logic [NUM_SLOTS-1:0][DELAY_W-1:0] delay;
   } rcss_st_t;

   rcss_st_t st_q, st_d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [SLOT_W-1:0] dec_slot;
   logic [CHAN_W-1:0] dec_ch;
   logic dec_ok;
   logic take_sel;
   logic [NUM_SLOTS-1:0] slot_any;
   rcss_tmr_if seq_t ();
   rcss_tmr_if pw_t ();

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   rcss_timer u_seq_tmr (
      .sys_clk(sys_clk),
      .rst_n_sync(rst_n),
      .clk_en(clk_en),
      .t(seq_t.tmr)
   );
   rcss_timer u_pw_tmr (
      .sys_clk(sys_clk),
      .rst_n_sync(rst_n),
      .clk_en(clk_en),
      .t(pw_t.tmr)
   );

   // Decode slot*100+ch and check range
   always_comb begin
      dec_slot = SLOT_W'(sel_number / NUM_W'(SLOT_FACTOR));
      dec_ch = CHAN_W'(sel_number % NUM_W'(SLOT_FACTOR));
      // Range judged on the full remainder, not on the cut channel field
      dec_ok = (sel_number / NUM_W'(SLOT_FACTOR)) >= NUM_W'(1)
         && (sel_number / NUM_W'(SLOT_FACTOR)) <= NUM_W'(NUM_SLOTS)
         && (sel_number % NUM_W'(SLOT_FACTOR)) >= NUM_W'(1);
      if (dec_ok) begin
         if (st_q.four_wire[dec_slot - SLOT_W'(1)]) begin
            dec_ok = (sel_number % NUM_W'(SLOT_FACTOR)) <= NUM_W'(FOUR_WIRE_CHANS);
         end else begin
            dec_ok = (sel_number % NUM_W'(SLOT_FACTOR)) <= NUM_W'(NUM_CHANS);
         end
      end
   end

   assign sel_ready = !st_q.pend_v;
   assign take_sel = sel_valid && sel_ready && dec_ok;
   assign sel_error = st_q.err;
   assign switch_done = st_q.done;
   assign switch_busy = (st_q.fsm != RCSS_IDLE) || st_q.pend_v;
   assign close_pulse = st_q.pulse;

   // Relay drive from registered state, one slot at a time
   genvar gs, gc;
   generate
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
         logic here;
         assign here = st_q.ch_closed && (st_q.cur_slot == SLOT_W'(gs + 1));
         assign bus_relay[gs] = st_q.bus_closed && (st_q.bus_slot == SLOT_W'(gs + 1));
         assign term2_route[gs] = st_q.four_wire[gs];
         for (gc = 0; gc < NUM_CHANS; gc++) begin : g_ch
            assign chan_relay[gs*NUM_CHANS+gc] = here && ((st_q.cur_ch == CHAN_W'(gc + 1))
               || (st_q.four_wire[gs] && st_q.cur_ch + CHAN_W'(SENSE_OFFSET) == CHAN_W'(gc + 1)));
         end
         assign slot_any[gs] = |chan_relay[gs*NUM_CHANS +: NUM_CHANS];
      end
   endgenerate

   always_comb begin
      st_d = st_q;
      st_d.err = sel_valid && sel_ready && !dec_ok;
      seq_t.start = 1'b0;
      seq_t.abort = 1'b0;
      seq_t.load = '0;
      pw_t.start = 1'b0;
      pw_t.abort = 1'b0;
      pw_t.load = TMR_W'(pulse_width_ms == '0 ? 1 : pulse_width_ms) * TMR_W'(MS_CYC);
      if (delay_wr && delay_slot >= SLOT_W'(1) && delay_slot <= SLOT_W'(NUM_SLOTS)
         && delay_ms <= DELAY_W'(DELAY_MAX_MS)) begin
         st_d.delay[delay_slot - SLOT_W'(1)] = delay_ms;
      end
      if (pw_t.expired) begin
         st_d.pulse = 1'b0;
      end
      case (st_q.fsm)
         RCSS_IDLE, RCSS_CLOSE, RCSS_DELAY: begin
            if (st_q.pend_v) begin
               // Restart: open the channel, and the bus relay if the slot changes, before anything new closes
               st_d.pend_v = 1'b0;
               st_d.new_slot = st_q.pend_slot;
               st_d.new_ch = st_q.pend_ch;
               st_d.ch_closed = 1'b0;
               if (st_q.bus_slot != st_q.pend_slot) begin
                  st_d.bus_closed = 1'b0;
               end
               seq_t.abort = 1'b1;
               if (st_q.ch_closed || st_q.bus_closed) begin
                  seq_t.start = 1'b1;
                  seq_t.load = TMR_W'(OPEN_CYC);
                  st_d.fsm = RCSS_OPEN;
               end else begin
                  seq_t.start = 1'b1;
                  seq_t.load = TMR_W'(GAP_SETTLE_CYC);
                  st_d.fsm = RCSS_GAP;
               end
               seq_t.abort = 1'b0;
            end else if (st_q.fsm == RCSS_CLOSE && seq_t.expired) begin
               seq_t.start = 1'b1;
               seq_t.load = TMR_W'(st_q.delay[st_q.cur_slot - SLOT_W'(1)]) * TMR_W'(MS_CYC);
               st_d.fsm = RCSS_DELAY;
            end else if (st_q.fsm == RCSS_DELAY && seq_t.expired) begin
               st_d.done = 1'b1;
               st_d.pulse = 1'b1;
               pw_t.start = 1'b1;
               st_d.fsm = RCSS_IDLE;
            end
         end
         RCSS_OPEN: begin
            if (seq_t.expired) begin
               seq_t.start = 1'b1;
               seq_t.load = TMR_W'(GAP_SETTLE_CYC);
               st_d.fsm = RCSS_GAP;
            end
         end
         RCSS_GAP: begin
            if (seq_t.expired) begin
               st_d.cur_slot = st_q.new_slot;
               st_d.cur_ch = st_q.new_ch;
               st_d.ch_closed = 1'b1;
               st_d.bus_closed = 1'b1;
               st_d.bus_slot = st_q.new_slot;
               seq_t.start = 1'b1;
               seq_t.load = TMR_W'(CLOSE_CYC);
               st_d.fsm = RCSS_CLOSE;
            end
         end
         default: begin
            st_d.fsm = RCSS_IDLE;
         end
      endcase
      // After the case, so a new selection beats a switch finishing in the same cycle
      if (take_sel) begin
         st_d.pend_v = 1'b1;
         st_d.pend_slot = dec_slot;
         st_d.pend_ch = dec_ch;
         st_d.done = 1'b0;
         st_d.pulse = 1'b0;
         pw_t.abort = 1'b1;
      end
      // Opening all or changing a method drops every channel
      if (open_all || (method_wr && method_slot >= SLOT_W'(1) && method_slot <= SLOT_W'(NUM_SLOTS))) begin
         st_d.ch_closed = 1'b0;
         st_d.bus_closed = 1'b0;
         st_d.done = 1'b0;
         st_d.pend_v = take_sel;
         st_d.fsm = RCSS_IDLE;
         seq_t.start = 1'b0;
         seq_t.abort = 1'b1;
      end
      if (method_wr && method_slot >= SLOT_W'(1) && method_slot <= SLOT_W'(NUM_SLOTS)) begin
         st_d.four_wire[method_slot - SLOT_W'(1)] = method_four_wire;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{fsm: RCSS_IDLE, delay: {NUM_SLOTS{DELAY_RESET}}, default: '0};
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !clk_en);

   sequence new_sel_s;
      take_sel && st_q.pulse;
   endsequence
   sequence opening_s;
      st_q.fsm == RCSS_OPEN;
   endsequence

   pulse_abort_a: assert property (new_sel_s |=> !close_pulse) else $error("pulse kept after new selection");
   open_before_close_a: assert property (opening_s |-> chan_relay == '0)
      else $error("channel closed in open step");
   no_overlap_a: assert property ($onehot0(slot_any)) else $error("two slots closed");
   one_slot_only_a: assert property ($onehot0(bus_relay)) else $error("two bus relays closed");
   same_slot_bus_a: assert property (opening_s and (st_q.new_slot == st_q.bus_slot && st_q.bus_closed)
      |-> bus_relay[st_q.bus_slot - SLOT_W'(1)]) else $error("bus relay opened in same slot");
   other_slot_bus_a: assert property (opening_s and (st_q.new_slot != st_q.bus_slot) |-> bus_relay == '0)
      else $error("old bus relay left closed");
   done_pulse_a: assert property ($rose(switch_done) |-> close_pulse && $past(st_q.fsm == RCSS_DELAY))
      else $error("completion without pulse");
   opc_closed_a: assert property (switch_done |-> st_q.ch_closed && |chan_relay) else $error("done while open");
   route_method_a: assert property (method_wr && method_slot == SLOT_W'(1)
      |=> term2_route[0] == $past(method_four_wire)) else $error("routing not following method");
   sense_pair_a: assert property (st_q.ch_closed && st_q.four_wire[st_q.cur_slot - SLOT_W'(1)]
      |-> $countones(chan_relay) == 2) else $error("four-wire pair missing");
endmodule

// *** verification/rcss_meter.sv ***
// Instrument model that times the completion pulse on the handshake port
`timescale 1ns/10ps
module rcss_meter (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Handshake port and completion status
   input wire logic close_pulse,
   input wire logic switch_done,
   // Observations
   output int last_width,
   output int reads_early
);
   int run;
   logic pulse_q;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run <= 0;
         last_width <= 0;
         reads_early <= 0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= close_pulse;
         if (close_pulse) begin
            run <= run + 1;
         end
         // Counts a pulse that rises while switch_done is not high as an early read
         if (close_pulse && !pulse_q && switch_done !== 1'b1) begin
            reads_early <= reads_early + 1;
         end
         if (!close_pulse && pulse_q) begin
            last_width <= run;
            run <= 0;
         end
      end
   end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the relay channel switch sequencer
`timescale 1ns/10ps
module tb;
   import rcss_pkg::*;
   localparam int OC = 20;
   localparam int GC = 4;
   localparam int CC = 20;
   localparam int MC = 10;
   localparam int CW = NUM_SLOTS*NUM_CHANS;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic sel_valid = 1'b0;
   logic [NUM_W-1:0] sel_number = '0;
   logic open_all = 1'b0;
   logic method_wr = 1'b0;
   logic method_four_wire = 1'b0;
   logic delay_wr = 1'b0;
   logic [SLOT_W-1:0] method_slot = '0;
   logic [SLOT_W-1:0] delay_slot = '0;
   logic [DELAY_W-1:0] delay_ms = '0;
   logic [WIDTH_W-1:0] pulse_width_ms = 8'h02;
   logic sel_ready, sel_error, switch_done, switch_busy, close_pulse;
   logic [NUM_SLOTS-1:0] bus_relay, term2_route;
   logic [CW-1:0] chan_relay;
   int num_errors = 0;
   int n_compared = 0;
   int max_on = 1;
   int last_width, reads_early;
   logic hold_bus = 1'b0;
   logic flag;

   always #5 sys_clk = ~sys_clk;

   rcss_sequencer #(.OPEN_CYC(OC), .GAP_SETTLE_CYC(GC), .CLOSE_CYC(CC), .MS_CYC(MC)) i_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .sel_valid(sel_valid), .sel_number(sel_number),
      .sel_ready(sel_ready), .sel_error(sel_error), .open_all(open_all), .method_wr(method_wr),
      .method_slot(method_slot), .method_four_wire(method_four_wire), .delay_wr(delay_wr),
      .delay_slot(delay_slot), .delay_ms(delay_ms), .pulse_width_ms(pulse_width_ms),
      .switch_done(switch_done), .switch_busy(switch_busy), .bus_relay(bus_relay),
      .chan_relay(chan_relay), .term2_route(term2_route), .close_pulse(close_pulse));

   rcss_meter i_meter (.sys_clk(sys_clk), .rst_b(rst_b), .close_pulse(close_pulse),
      .switch_done(switch_done), .last_width(last_width), .reads_early(reads_early));

   task automatic check(input string what, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   function automatic logic [CW-1:0] ch(input int s, input int c);
      ch = '0;
      ch[(s-1)*NUM_CHANS+c-1] = 1'b1;
   endfunction

   // Offer a selection and hold it through the first edge with sel_ready high
   task automatic sel(input logic [NUM_W-1:0] n);
      int k;
      k = 0;
      sel_valid <= 1'b1;
      sel_number <= n;
      @(negedge sys_clk);
      while (sel_ready !== 1'b1 && k < 500) begin
         @(negedge sys_clk);
         k++;
      end
      @(posedge sys_clk);
      sel_valid <= 1'b0;
   endtask

   task automatic wait_done(input int lo, input int hi);
      int k;
      k = 0;
      @(negedge sys_clk);
      while (switch_done !== 1'b1 && k < 3000) begin
         @(negedge sys_clk);
         k++;
      end
      check("done latency", CW'(k >= lo && k <= hi), CW'(1));
      check("relay closed at done", CW'(chan_relay != '0), CW'(1));
      check("idle at done", CW'(switch_busy), CW'(0));
      @(posedge sys_clk);
   endtask

   task automatic cfg(input logic m, input logic [SLOT_W-1:0] s, input logic [DELAY_W-1:0] v);
      method_wr <= m;
      delay_wr <= !m;
      method_slot <= s;
      delay_slot <= s;
      method_four_wire <= v[0];
      delay_ms <= v;
      @(posedge sys_clk);
      method_wr <= 1'b0;
      delay_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic bad(input logic [NUM_W-1:0] n);
      sel(n);
      flag = 1'b0;
      repeat (2) begin
         @(negedge sys_clk);
         flag = flag | sel_error;
      end
      check("illegal flagged", CW'(flag), CW'(1));
      @(posedge sys_clk);
   endtask

   // Overlap and bus relay watch
   always @(negedge sys_clk) begin
      if (rst_b && $countones(chan_relay) > max_on)
         check("closed channel count", CW'($countones(chan_relay)), CW'(max_on));
      if (hold_bus)
         check("same slot bus relay", CW'(bus_relay[0]), CW'(1));
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("idle relays", chan_relay, '0);
      sel(16'd107);
      wait_done(GC+CC-2, GC+CC+8);
      check("slot 1 ch 7", chan_relay, ch(1, 7));
      check("slot 1 bus", CW'(bus_relay), CW'(12'h001));
      while (close_pulse === 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      check("pulse width", CW'(last_width == 2*MC || last_width == 2*MC+1), CW'(1));
      @(posedge sys_clk);
      $display("test first switch done");
      hold_bus <= 1'b1;
      sel(16'd103);
      wait_done(OC+GC+CC-2, OC+GC+CC+8);
      hold_bus <= 1'b0;
      check("slot 1 ch 3", chan_relay, ch(1, 3));
      sel(16'd1222);
      wait_done(OC+GC+CC-2, OC+GC+CC+8);
      check("slot 12 bus", CW'(bus_relay), CW'(12'h800));
      check("slot 12 ch 22", chan_relay, ch(12, 22));
      $display("test slot change done");
      cfg(1'b0, 4'h2, 14'd3);
      cfg(1'b0, 4'h2, 14'd10000);
      sel(16'd201);
      wait_done(OC+GC+CC+3*MC-2, OC+GC+CC+3*MC+8);
      pulse_width_ms <= 8'd50;
      sel(16'd202);
      wait_done(OC+GC+CC+3*MC-2, OC+GC+CC+3*MC+8);
      repeat (5) @(posedge sys_clk);
      sel(16'd203);
      @(negedge sys_clk);
      check("pulse cut", CW'({close_pulse, switch_done}), CW'(0));
      check("ready while pending", CW'({switch_busy, sel_ready}), CW'(2'b10));
      @(posedge sys_clk);
      sel(16'd204);
      wait_done(OC+GC+CC+3*MC, 2*(OC+GC+CC+3*MC)+20);
      check("held selection", chan_relay, ch(2, 4));
      check("cut width", CW'(last_width > 0 && last_width < 50*MC), CW'(1));
      pulse_width_ms <= 8'h02;
      $display("test delay and cut done");
      max_on = 2;
      cfg(1'b1, 4'h1, 14'd1);
      check("four wire route", CW'({term2_route, switch_done}), CW'(13'h0002));
      check("method opens all", chan_relay, '0);
      @(posedge sys_clk);
      sel(16'd101);
      wait_done(GC+CC-2, GC+CC+8);
      check("four wire pair", chan_relay, ch(1, 1) | ch(1, 12));
      bad(16'd112);
      check("pair kept", chan_relay, ch(1, 1) | ch(1, 12));
      cfg(1'b1, 4'h1, 14'd0);
      max_on = 1;
      check("two wire route", CW'(term2_route), '0);
      @(posedge sys_clk);
      sel(16'd112);
      wait_done(GC+CC-2, GC+CC+8);
      check("sense line", chan_relay, ch(1, 12));
      $display("test connection method done");
      bad(16'd1300);
      bad(16'd140);
      bad(16'd100);
      bad(16'd123);
      open_all <= 1'b1;
      @(posedge sys_clk);
      open_all <= 1'b0;
      @(negedge sys_clk);
      check("open all", chan_relay | CW'({bus_relay, switch_done}), '0);
      check("no early trigger", CW'(reads_early), '0);
      $display("test refusal and open done");
      complete_run();
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      check("watchdog", '0, CW'(1));
      complete_run();
   end
endmodule
